// file: src/tio_map.svh
// tio_map.svh: register offsets, field positions and reset values of
// the timer pin I/O control block for channels 2 and 3.
// assumes byte addresses on a 32-bit Avalon-MM slave, one word each.
`ifndef TIO_MAP_SVH
`define TIO_MAP_SVH
`define TIO_OFS_CTRL_2B    8'h00
`define TIO_OFS_CTRL_3B    8'h04
`define TIO_OFS_CTRL_3D    8'h08
`define TIO_OFS_MODE_3     8'h0C
`define TIO_OFS_CTRL_4     8'h10
`define TIO_OFS_GR_2B      8'h14
`define TIO_OFS_GR_3B      8'h18
`define TIO_OFS_GR_3D      8'h1C
`define TIO_OFS_PINS       8'h20
`define TIO_FLD_HI         7
`define TIO_FLD_LO         4
`define TIO_FLD_RST        4'h0
`define TIO_D_BUF_BIT      0
`define TIO_D_BUF_RST      1'h0
`define TIO_PSC_HI         2
`define TIO_PSC_LO         0
`define TIO_PSC_RST        3'h0
`define TIO_PSC_UNDIVIDED  3'h0
`define TIO_GR_RST         16'hFFFF
`define TIO_PINS_OE_LO     4
`endif

// file: src/tio_pkg.sv
// tio_pkg: types shared by the timer pin I/O control block.
// assumes tio_map.svh holds all offsets and reset values.
package tio_pkg;
    parameter int TIO_GR_W = 16;   // general register width
    // role decoded from a 4-bit control field
    typedef enum logic [1:0]
    {
        TIO_ROLE_OFF     = 2'b00,
        TIO_ROLE_COMPARE = 2'b01,
        TIO_ROLE_CAP_PIN = 2'b10,
        TIO_ROLE_CAP_CNT = 2'b11
    } tio_role_type;
    // synchroniser and edge detector state
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } tio_edge_state_type;
    // one general register with its pin
    typedef struct packed {
        logic [TIO_GR_W-1:0] gr;
        logic                pin_o;
        logic                cap;
    } tio_unit_state_type;
    // top-level bus and control state
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [3:0]  ctrl_2b;
        logic [3:0]  ctrl_3b;
        logic [3:0]  ctrl_3d;
        logic        d_buf;
        logic [2:0]  psc;
        logic [2:0]  fwr;
    } tio_top_state_type;
endpackage

// file: src/tio_pin_edge.sv
// tio_pin_edge: two-flop synchroniser for a timer pin with edge pulses.
// assumes the pin is asynchronous to CLK; edges show two clocks late.
`timescale 1ns/100ps
`default_nettype none
module tio_pin_edge
    import tio_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_i,
    output logic      rise,
    output logic      fall
);
    tio_edge_state_type st;       // registered state
    tio_edge_state_type next_st;  // next state

    // shift chain; s1 feeds only s2
    always_comb
    begin
        next_st      = st;
        next_st.s1   = pin_i;
        next_st.s2   = st.s1;
        next_st.prev = st.s2;
    end

    // register the state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    // edges seen past the synchroniser only
    assign rise = st.s2 & ~st.prev;
    assign fall = ~st.s2 & st.prev;
endmodule // tio_pin_edge
`default_nettype wire

// file: src/tio_gr_unit.sv
// tio_gr_unit: one general register with its control field and pin.
// assumes field and field_wr come from flops of the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "tio_map.svh"
module tio_gr_unit
    import tio_pkg::*;
#(
    parameter bit HAS_CNT_CAP = 1'b0   // channel 3 style count capture
)
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [3:0]          field,      // control field
    input  wire logic                field_wr,   // field just written
    input  wire logic                blocked,    // buffer mode
    input  wire logic                cnt_cap_ok, // count capture usable
    input  wire logic [TIO_GR_W-1:0] count,      // owning counter
    input  wire logic                count_tick, // counter updated
    input  wire logic                pin_rise,
    input  wire logic                pin_fall,
    input  wire logic                cnt_event,  // ch4 counted
    input  wire logic                sw_wr,
    input  wire logic [TIO_GR_W-1:0] sw_data,
    input  wire logic [1:0]          sw_be,
    output logic [TIO_GR_W-1:0]      gr,
    output logic                     pin_o,
    output logic                     pin_oe,
    output logic                     capture
);
    tio_unit_state_type st;       // registered state
    tio_unit_state_type next_st;  // next state
    tio_role_type       role;     // decoded role
    logic               match;    // compare match this cycle
    logic               cap;      // capture event this cycle

    // decode role, find events, update register and pin
    always_comb
    begin
        next_st = st;
        if (!field[3])
            role = (field[1:0] == 2'b00) ? TIO_ROLE_OFF : TIO_ROLE_COMPARE;
        else if (HAS_CNT_CAP && field[2])
            role = TIO_ROLE_CAP_CNT;
        else
            role = TIO_ROLE_CAP_PIN;  // bit 6 ignored without count capture
        match = count_tick && (count == st.gr) && (role == TIO_ROLE_COMPARE)
                && !blocked;
        cap = 1'b0;
        if (role == TIO_ROLE_CAP_PIN && !blocked)
        begin
            if (field[1])
                cap = pin_rise | pin_fall;
            else if (field[0])
                cap = pin_fall;
            else
                cap = pin_rise;
        end
        if (role == TIO_ROLE_CAP_CNT && !blocked)
            cap = cnt_event && cnt_cap_ok;
        // software write, capture wins if both land together
        if (sw_wr && sw_be[0])
            next_st.gr[7:0] = sw_data[7:0];
        if (sw_wr && sw_be[1])
            next_st.gr[TIO_GR_W-1:8] = sw_data[TIO_GR_W-1:8];
        if (cap)
            next_st.gr = count;
        next_st.cap = cap;
        // initial level on field write, else compare action
        if (field_wr && role == TIO_ROLE_COMPARE)
            next_st.pin_o = field[2];
        else if (match)
        begin
            case (field[1:0])
                2'b01:   next_st.pin_o = 1'b0;
                2'b10:   next_st.pin_o = 1'b1;
                2'b11:   next_st.pin_o = ~st.pin_o;
                default: next_st.pin_o = st.pin_o;
            endcase
        end
    end

    // register the state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st.gr    <= `TIO_GR_RST;
            st.pin_o <= 1'b0;
            st.cap   <= 1'b0;
        end
        else
            st <= next_st;
    end

    assign gr      = st.gr;
    assign pin_o   = st.pin_o;
    // drive only in compare roles; 0000 and 0100 release the pin
    assign pin_oe  = (role == TIO_ROLE_COMPARE) && !blocked;
    assign capture = st.cap;
endmodule // tio_gr_unit
`default_nettype wire

// file: src/tio_io_ctrl.sv
// tio_io_ctrl: pin I/O control of general registers B of channel 2,
// and B and D of channel 3, with an Avalon-MM register slave.
// assumes counters and the ch4 count event come from CLK-domain logic;
// timer pins are asynchronous and are synchronised here.
//
// Contract
// - field bits 7:4, reset 0; 0001 low
// - compare code x010 drives pin high
// - compare code x011 toggles the pin
// - 0100 off; 0101-0111 start high
// - 1x00 captures on pin rising edge
// - capture code 1x01 uses falling edge
// - capture code 1x1x uses both edges
// - ch3 code 11xx captures on ch4 counting
// - no count capture when ch4 undivided
// - D buffer mode kills capture, compare
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "tio_map.svh"
module tio_io_ctrl
    import tio_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                RST,
    // avalon-mm slave
    input  wire logic [7:0]          AVS_ADDRESS,
    input  wire logic                AVS_READ,
    input  wire logic                AVS_WRITE,
    input  wire logic [31:0]         AVS_WRITEDATA,
    input  wire logic [3:0]          AVS_BYTEENABLE,
    output logic [31:0]              AVS_READDATA,
    output logic                     AVS_WAITREQUEST,
    // counters of channels 2 and 3 and ch4 count event
    input  wire logic [TIO_GR_W-1:0] CH2_COUNT,
    input  wire logic                CH2_COUNT_TICK,
    input  wire logic [TIO_GR_W-1:0] CH3_COUNT,
    input  wire logic                CH3_COUNT_TICK,
    input  wire logic                CH4_COUNT_EVENT,
    // timer pins, split into input, output and enable
    input  wire logic                CH2_PIN_B_I,
    output logic                     CH2_PIN_B_O,
    output logic                     CH2_PIN_B_OE,
    input  wire logic                CH3_PIN_B_I,
    output logic                     CH3_PIN_B_O,
    output logic                     CH3_PIN_B_OE,
    input  wire logic                CH3_PIN_D_I,
    output logic                     CH3_PIN_D_O,
    output logic                     CH3_PIN_D_OE,
    // capture pulses: bit 0 ch2 B, bit 1 ch3 B, bit 2 ch3 D
    output logic [2:0]               CAPTURE
);
    tio_top_state_type   st;        // registered state
    tio_top_state_type   next_st;   // next state
    logic                access;    // a request is on the bus
    logic                commit;    // request completes this cycle
    logic [3:0]          wr_sel;    // field and mode register write selects
    logic [2:0]          gr_wr;     // general register write selects
    logic [TIO_GR_W-1:0] gr_2b;     // ch2 general register b
    logic [TIO_GR_W-1:0] gr_3b;     // ch3 general register b
    logic [TIO_GR_W-1:0] gr_3d;     // ch3 general register d
    logic [2:0]          rise;      // synchronised rising edges
    logic [2:0]          fall;      // synchronised falling edges
    logic                cnt_ok;    // ch4 count capture allowed
    logic                wr_lo;     // low byte lane enabled

    // one wait state per access: readdata is built while waitrequest is
    // high, so it stands settled at the edge where waitrequest drops
    assign access          = AVS_READ | AVS_WRITE;
    assign commit          = access & st.ack;
    assign AVS_WAITREQUEST = access & ~st.ack;
    assign AVS_READDATA    = st.rdata;
    assign wr_lo           = AVS_WRITE & commit & AVS_BYTEENABLE[0];

    // count capture is pointless on the undivided clock
    assign cnt_ok = (st.psc != `TIO_PSC_UNDIVIDED);

    // address decode of write strobes
    always_comb
    begin
        wr_sel = 4'h0;
        gr_wr  = 3'h0;
        if (AVS_WRITE && commit)
        begin
            case (AVS_ADDRESS)
                `TIO_OFS_CTRL_2B: wr_sel[0] = 1'b1;
                `TIO_OFS_CTRL_3B: wr_sel[1] = 1'b1;
                `TIO_OFS_CTRL_3D: wr_sel[2] = 1'b1;
                `TIO_OFS_MODE_3:  wr_sel[3] = 1'b1;
                `TIO_OFS_GR_2B:   gr_wr[0]  = 1'b1;
                `TIO_OFS_GR_3B:   gr_wr[1]  = 1'b1;
                `TIO_OFS_GR_3D:   gr_wr[2]  = 1'b1;
                default:          gr_wr     = 3'h0;  // unmapped: ignored
            endcase
        end
    end

    // bus handshake, control registers and read mux
    always_comb
    begin
        next_st     = st;
        next_st.ack = access & ~st.ack;
        next_st.fwr = 3'h0;
        // field writes; the pulse follows the new field by no cycle
        if (wr_sel[0] && wr_lo)
        begin
            next_st.ctrl_2b = AVS_WRITEDATA[`TIO_FLD_HI:`TIO_FLD_LO];
            next_st.fwr[0]  = 1'b1;
        end
        if (wr_sel[1] && wr_lo)
        begin
            next_st.ctrl_3b = AVS_WRITEDATA[`TIO_FLD_HI:`TIO_FLD_LO];
            next_st.fwr[1]  = 1'b1;
        end
        if (wr_sel[2] && wr_lo)
        begin
            next_st.ctrl_3d = AVS_WRITEDATA[`TIO_FLD_HI:`TIO_FLD_LO];
            next_st.fwr[2]  = 1'b1;
        end
        // channel 3 mode: buffer mode bit of register d
        if (wr_sel[3] && wr_lo)
            next_st.d_buf = AVS_WRITEDATA[`TIO_D_BUF_BIT];
        // channel 4 control: prescaler select
        if (AVS_WRITE && commit && AVS_BYTEENABLE[0]
            && AVS_ADDRESS == `TIO_OFS_CTRL_4)
            next_st.psc = AVS_WRITEDATA[`TIO_PSC_HI:`TIO_PSC_LO];
        // read data captured in the wait cycle; unmapped reads give zero
        next_st.rdata = 32'h0000_0000;
        if (AVS_READ && !st.ack)
        begin
            case (AVS_ADDRESS)
                `TIO_OFS_CTRL_2B:
                    next_st.rdata[`TIO_FLD_HI:`TIO_FLD_LO] = st.ctrl_2b;
                `TIO_OFS_CTRL_3B:
                    next_st.rdata[`TIO_FLD_HI:`TIO_FLD_LO] = st.ctrl_3b;
                `TIO_OFS_CTRL_3D:
                    next_st.rdata[`TIO_FLD_HI:`TIO_FLD_LO] = st.ctrl_3d;
                `TIO_OFS_MODE_3:
                    next_st.rdata[`TIO_D_BUF_BIT] = st.d_buf;
                `TIO_OFS_CTRL_4:
                    next_st.rdata[`TIO_PSC_HI:`TIO_PSC_LO] = st.psc;
                `TIO_OFS_GR_2B:
                    next_st.rdata[TIO_GR_W-1:0] = gr_2b;
                `TIO_OFS_GR_3B:
                    next_st.rdata[TIO_GR_W-1:0] = gr_3b;
                `TIO_OFS_GR_3D:
                    next_st.rdata[TIO_GR_W-1:0] = gr_3d;
                `TIO_OFS_PINS:
                begin
                    // live pin levels and enables
                    next_st.rdata[2:0] = {CH3_PIN_D_O, CH3_PIN_B_O, CH2_PIN_B_O};
                    next_st.rdata[`TIO_PINS_OE_LO+2:`TIO_PINS_OE_LO] =
                        {CH3_PIN_D_OE, CH3_PIN_B_OE, CH2_PIN_B_OE};
                end
                default:
                    next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // register the state; fields reset to output disabled
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            st.ack     <= 1'b0;
            st.rdata   <= 32'h0000_0000;
            st.ctrl_2b <= `TIO_FLD_RST;
            st.ctrl_3b <= `TIO_FLD_RST;
            st.ctrl_3d <= `TIO_FLD_RST;
            st.d_buf   <= `TIO_D_BUF_RST;
            st.psc     <= `TIO_PSC_RST;
            st.fwr     <= 3'h0;
        end
        else
            st <= next_st;
    end

    // pin synchronisers; output-only use simply ignores the edges
    tio_pin_edge u_edge_2b
    (
        .clk   (CLK),
        .rst   (RST),
        .pin_i (CH2_PIN_B_I),
        .rise  (rise[0]),
        .fall  (fall[0])
    );
    tio_pin_edge u_edge_3b
    (
        .clk   (CLK),
        .rst   (RST),
        .pin_i (CH3_PIN_B_I),
        .rise  (rise[1]),
        .fall  (fall[1])
    );
    tio_pin_edge u_edge_3d
    (
        .clk   (CLK),
        .rst   (RST),
        .pin_i (CH3_PIN_D_I),
        .rise  (rise[2]),
        .fall  (fall[2])
    );

    // channel 2 register b: no count capture, bit 6 is don't-care in capture codes
    tio_gr_unit #(.HAS_CNT_CAP (1'b0)) u_gr_2b
    (
        .clk        (CLK),
        .rst        (RST),
        .field      (st.ctrl_2b),
        .field_wr   (st.fwr[0]),
        .blocked    (1'b0),
        .cnt_cap_ok (1'b0),
        .count      (CH2_COUNT),
        .count_tick (CH2_COUNT_TICK),
        .pin_rise   (rise[0]),
        .pin_fall   (fall[0]),
        .cnt_event  (1'b0),
        .sw_wr      (gr_wr[0]),
        .sw_data    (AVS_WRITEDATA[TIO_GR_W-1:0]),
        .sw_be      (AVS_BYTEENABLE[1:0]),
        .gr         (gr_2b),
        .pin_o      (CH2_PIN_B_O),
        .pin_oe     (CH2_PIN_B_OE),
        .capture    (CAPTURE[0])
    );

    // channel 3 register b: may capture on ch4 counting
    tio_gr_unit #(.HAS_CNT_CAP (1'b1)) u_gr_3b
    (
        .clk        (CLK),
        .rst        (RST),
        .field      (st.ctrl_3b),
        .field_wr   (st.fwr[1]),
        .blocked    (1'b0),
        .cnt_cap_ok (cnt_ok),
        .count      (CH3_COUNT),
        .count_tick (CH3_COUNT_TICK),
        .pin_rise   (rise[1]),
        .pin_fall   (fall[1]),
        .cnt_event  (CH4_COUNT_EVENT),
        .sw_wr      (gr_wr[1]),
        .sw_data    (AVS_WRITEDATA[TIO_GR_W-1:0]),
        .sw_be      (AVS_BYTEENABLE[1:0]),
        .gr         (gr_3b),
        .pin_o      (CH3_PIN_B_O),
        .pin_oe     (CH3_PIN_B_OE),
        .capture    (CAPTURE[1])
    );

    // channel 3 register d: silenced while used as a buffer
    tio_gr_unit #(.HAS_CNT_CAP (1'b1)) u_gr_3d
    (
        .clk        (CLK),
        .rst        (RST),
        .field      (st.ctrl_3d),
        .field_wr   (st.fwr[2]),
        .blocked    (st.d_buf),
        .cnt_cap_ok (cnt_ok),
        .count      (CH3_COUNT),
        .count_tick (CH3_COUNT_TICK),
        .pin_rise   (rise[2]),
        .pin_fall   (fall[2]),
        .cnt_event  (CH4_COUNT_EVENT),
        .sw_wr      (gr_wr[2]),
        .sw_data    (AVS_WRITEDATA[TIO_GR_W-1:0]),
        .sw_be      (AVS_BYTEENABLE[1:0]),
        .gr         (gr_3d),
        .pin_o      (CH3_PIN_D_O),
        .pin_oe     (CH3_PIN_D_OE),
        .capture    (CAPTURE[2])
    );
endmodule // tio_io_ctrl
`default_nettype wire

// file: testbench/tio_pin_model.sv
// tio_pin_model: the board side of the three timer pins.
// assumes the outside source drives ext all the time.
`timescale 1ns/100ps
`default_nettype none
module tio_pin_model
(
    input  wire logic [2:0] oe,   // block drives the pin
    input  wire logic [2:0] o,    // block pin level
    input  wire logic [2:0] ext,  // outside source level
    output logic      [2:0] pin   // resolved wire level
);
    // the block wins where it drives; the outside source is weaker
    assign pin = (oe & o) | (~oe & ext);
endmodule // tio_pin_model
`default_nettype wire

// file: testbench/tio_io_ctrl_chk.sv
// tio_io_ctrl_chk: port-level assertions for the timer pin I/O control.
// assumes a master that holds each request until waitrequest is low.
`timescale 1ns/100ps
`default_nettype none
module tio_io_ctrl_chk
    import tio_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       AVS_READ,
    input wire logic       AVS_WRITE,
    input wire logic       AVS_WAITREQUEST,
    input wire logic       CH2_COUNT_TICK,
    input wire logic       CH3_COUNT_TICK,
    input wire logic       CH4_COUNT_EVENT,
    input wire logic       CH2_PIN_B_I,
    input wire logic       CH3_PIN_B_I,
    input wire logic       CH3_PIN_D_I,
    input wire logic       CH2_PIN_B_O,
    input wire logic       CH3_PIN_D_O,
    input wire logic       CH2_PIN_B_OE,
    input wire logic       CH3_PIN_B_OE,
    input wire logic       CH3_PIN_D_OE,
    input wire logic [2:0] CAPTURE
);
    logic [17:0] hist;  // six samples of the three pins
    logic [14:0] chg;   // sample-to-sample changes
    logic [2:0]  moved; // pin moved within the capture latency
    wire         wr_done = AVS_WRITE & ~AVS_WAITREQUEST;  // write committed this cycle
    // history covers sync plus detect delay with two cycles to spare
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            hist <= 18'h00000;
        else
            hist <= {hist[14:0], CH3_PIN_D_I, CH3_PIN_B_I, CH2_PIN_B_I};
    end
    assign chg   = hist[14:0] ^ hist[17:3];
    assign moved = chg[2:0] | chg[5:3] | chg[8:6] | chg[11:9] | chg[14:12];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered after one cycle");
    a_wait_idle: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("waitrequest without request");
    a_reset_off: assert property ($fell(RST) |-> CAPTURE == 3'h0 && !CH2_PIN_B_OE
        && !CH3_PIN_B_OE && !CH3_PIN_D_OE) else $error("pins driven after reset");
    a_cap_no_drive: assert property ((CAPTURE & {CH3_PIN_D_OE, CH3_PIN_B_OE,
        CH2_PIN_B_OE}) == 3'h0) else $error("capture on a driven pin");
    a_cap2_cause: assert property (CAPTURE[0] |-> moved[0])
        else $error("ch2 capture without pin edge");
    a_cap3b_cause: assert property (CAPTURE[1] |-> moved[1] || $past(CH4_COUNT_EVENT))
        else $error("ch3 b capture without cause");
    a_cap3d_cause: assert property (CAPTURE[2] |-> moved[2] || $past(CH4_COUNT_EVENT))
        else $error("ch3 d capture without cause");
    a_cap2_pulse: assert property (CAPTURE[0] |=> !CAPTURE[0])
        else $error("ch2 capture pulse too long");
    a_o2_cause: assert property ($changed(CH2_PIN_B_O) |-> $past(CH2_COUNT_TICK)
        || $past(wr_done, 2)) else $error("ch2 pin level changed without cause");
    a_o3d_cause: assert property ($changed(CH3_PIN_D_O) |-> $past(CH3_COUNT_TICK)
        || $past(wr_done, 2)) else $error("ch3 d pin level changed without cause");
    c_pin_cap: cover property (CAPTURE[0]);
    c_cnt_cap: cover property (CAPTURE[1] && $past(CH4_COUNT_EVENT));
    c_d_level: cover property ($changed(CH3_PIN_D_O));
endmodule // tio_io_ctrl_chk
bind tio_io_ctrl tio_io_ctrl_chk i_tio_io_ctrl_chk (.CLK, .RST, .AVS_READ, .AVS_WRITE,
    .AVS_WAITREQUEST, .CH2_COUNT_TICK, .CH3_COUNT_TICK, .CH4_COUNT_EVENT, .CH2_PIN_B_I,
    .CH3_PIN_B_I, .CH3_PIN_D_I, .CH2_PIN_B_O, .CH3_PIN_D_O, .CH2_PIN_B_OE, .CH3_PIN_B_OE,
    .CH3_PIN_D_OE, .CAPTURE);
`default_nettype wire

// file: testbench/tio_io_ctrl_test.sv
// tio_io_ctrl_test: self-checking bench, register reads scored by a queue.
// assumes the pin model stands between the block and the outside source.
`timescale 1ns/100ps
`default_nettype none
`include "tio_map.svh"
module tio_io_ctrl_test
    import tio_pkg::*;
;
    logic        clk = 1'b0;         // 125 MHz
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wait_req;
    logic [15:0] cnt2 = 16'h0000;
    logic [15:0] cnt3 = 16'h0000;
    logic [2:0]  pls = 3'h0;          // ch2 tick, ch3 tick, ch4 event
    logic [2:0]  ext = 3'h0;          // outside pin source
    logic [2:0]  pin_in, pin_o, pin_oe, cap;
    logic [63:0] exp_q[$];            // mask over expected read data
    int          cap_n = 0;           // capture pulses seen so far
    int          mismatches = 0;
    int          checks_done = 0;
    logic [15:0] seed = 16'h0024;
    logic [15:0] gr_m[3];             // tracked general registers
    logic [7:0]  cap_tab[8] = '{8'h08, 8'h09, 8'h0A, 8'h0C, 8'h18, 8'h19, 8'h1B, 8'h2A};
    tio_io_ctrl i_tio_io_ctrl (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_req), .CH2_COUNT(cnt2), .CH2_COUNT_TICK(pls[0]),
        .CH3_COUNT(cnt3), .CH3_COUNT_TICK(pls[1]), .CH4_COUNT_EVENT(pls[2]),
        .CH2_PIN_B_I(pin_in[0]), .CH2_PIN_B_O(pin_o[0]), .CH2_PIN_B_OE(pin_oe[0]),
        .CH3_PIN_B_I(pin_in[1]), .CH3_PIN_B_O(pin_o[1]), .CH3_PIN_B_OE(pin_oe[1]),
        .CH3_PIN_D_I(pin_in[2]), .CH3_PIN_D_O(pin_o[2]), .CH3_PIN_D_OE(pin_oe[2]),
        .CAPTURE(cap));
    tio_pin_model i_tio_pin_model (.oe(pin_oe), .o(pin_o), .ext(ext), .pin(pin_in));
    // free-running clock
    initial
        forever #4 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic fail(input string m);
        mismatches++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    // one avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr_en <= w;
        rd_en <= ~w;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_req !== 1'b0 && n < 64);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (n >= 64)
        begin
            fail("bus timeout");
            close_out();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask
    // one-cycle strobe on a counter input
    task automatic pulse(input int k);
        @(posedge clk);
        pls[k] <= 1'b1;
        @(posedge clk);
        pls <= 3'h0;
    endtask
    // scoreboard: read data taken at the completing edge only; counts capture pulses
    always @(posedge clk)
    begin
        cap_n <= cap_n + $countones(cap);
        if (rd_en && wait_req === 1'b0)
        begin
            checks_done++;
            if (exp_q.size() == 0)
                fail("unexpected read");
            else if (((rdat ^ exp_q[0][31:0]) & exp_q[0][63:32]) !== 32'h0)
                fail("read data mismatch");
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end
    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        fail("run timeout");
        close_out();
    end
    initial
    begin
        logic [3:0] cd;
        logic       oe, lvl;
        int         u, c0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rd(`TIO_OFS_CTRL_2B + 8'(4 * i), 32'h0, 32'hF0);
            rd(`TIO_OFS_GR_2B + 8'(4 * i), {16'h0, `TIO_GR_RST}, 32'hFFFF);
        end
        rd(`TIO_OFS_PINS, 32'h0, 32'h77);
        rd(8'h24, 32'h0, 32'hFFFFFFFF);
        // every compare code on every unit: initial level then match action
        for (u = 0; u < 3; u++)
        begin
            seed = lfsr(seed);
            gr_m[u] = seed;
            bus(1'b1, `TIO_OFS_GR_2B + 8'(4 * u), {16'h0, seed});
            for (int c = 1; c < 8; c++)
            begin
                cd = 4'(c);
                oe = (cd[1:0] != 2'b00);
                bus(1'b1, `TIO_OFS_CTRL_2B + 8'(4 * u), {24'h0, cd, 4'h0});
                repeat (3) @(posedge clk);
                rd(`TIO_OFS_PINS, (32'(oe) << (u + 4)) | (32'(cd[2]) << u),
                    (32'h1 << (u + 4)) | (32'(oe) << u));
                cnt2 <= seed;
                cnt3 <= seed;
                pulse(u == 0 ? 0 : 1);
                repeat (2) @(posedge clk);
                lvl = (cd[1:0] == 2'b01) ? 1'b0 : (cd[1:0] == 2'b10) ? 1'b1 : ~cd[2];
                rd(`TIO_OFS_PINS, (32'(oe) << (u + 4)) | (32'(lvl) << u),
                    (32'h1 << (u + 4)) | (32'(oe) << u));
            end
            bus(1'b1, `TIO_OFS_CTRL_2B + 8'(4 * u), 32'h0);
        end
        // pin capture codes; counter parked so a release glitch is harmless
        for (int t = 0; t < 8; t++)
        begin
            u = int'(cap_tab[t][5:4]);
            cd = cap_tab[t][3:0];
            cnt2 <= gr_m[0];
            cnt3 <= gr_m[u];
            bus(1'b1, `TIO_OFS_CTRL_2B + 8'(4 * u), {24'h0, cd, 4'h0});
            repeat (8) @(posedge clk);
            for (int e = 0; e < 2; e++)
            begin
                seed = lfsr(seed);
                cnt2 <= seed;
                cnt3 <= seed;
                c0 = cap_n;
                @(posedge clk);
                ext[u] <= (e == 0);
                repeat (8) @(posedge clk);
                checks_done++;
                if ((cap_n - c0) != int'(cd[1] || cd[1:0] == 2'(e)))
                    fail("capture pulse count");
                if (cd[1] || cd[1:0] == 2'(e))
                    gr_m[u] = seed;
                rd(`TIO_OFS_GR_2B + 8'(4 * u), {16'h0, gr_m[u]}, 32'hFFFF);
            end
            bus(1'b1, `TIO_OFS_CTRL_2B + 8'(4 * u), 32'h0);
        end
        // count capture on ch3 b: idle with undivided prescaler, then live
        bus(1'b1, `TIO_OFS_CTRL_3B, 32'hC0);
        seed = lfsr(seed);
        cnt3 <= seed;
        pulse(2);
        rd(`TIO_OFS_GR_3B, {16'h0, gr_m[1]}, 32'hFFFF);
        bus(1'b1, `TIO_OFS_CTRL_4, 32'h1);
        pulse(2);
        rd(`TIO_OFS_GR_3B, {16'h0, seed}, 32'hFFFF);
        // buffer mode on d: no capture and pin released
        bus(1'b1, `TIO_OFS_MODE_3, 32'h1);
        bus(1'b1, `TIO_OFS_CTRL_3D, 32'hC0);
        seed = lfsr(seed);
        cnt3 <= seed;
        pulse(2);
        rd(`TIO_OFS_GR_3D, {16'h0, gr_m[2]}, 32'hFFFF);
        bus(1'b1, `TIO_OFS_CTRL_3D, 32'h50);
        repeat (3) @(posedge clk);
        rd(`TIO_OFS_PINS, 32'h0, 32'h40);
        bus(1'b1, `TIO_OFS_CTRL_3D, 32'hC0);
        bus(1'b1, `TIO_OFS_MODE_3, 32'h0);
        pulse(2);
        rd(`TIO_OFS_GR_3D, {16'h0, seed}, 32'hFFFF);
        repeat (10) @(posedge clk);
        if (exp_q.size() != 0)
            fail("reads left unscored");
        close_out();
    end
endmodule // tio_io_ctrl_test
`default_nettype wire
